// ---- adv_timer_pkg.sv ----
package adv_timer_pkg;

  // Register byte addresses.
  localparam logic [7:0] MASK_OFFSET        = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET      = 8'h10;
  localparam logic [7:0] CH12_MODE_OFFSET   = 8'h18;
  localparam logic [7:0] CH34_MODE_OFFSET   = 8'h1c;
  localparam logic [7:0] ENABLE_OFFSET      = 8'h20;
  localparam logic [7:0] COUNTER_OFFSET     = 8'h24;
  localparam logic [7:0] DIVIDER_OFFSET     = 8'h28;
  localparam logic [7:0] RELOAD_OFFSET      = 8'h2c;
  localparam logic [7:0] REPEAT_OFFSET      = 8'h30;
  localparam logic [7:0] CH1_VALUE_OFFSET   = 8'h34;
  localparam logic [7:0] CH2_VALUE_OFFSET   = 8'h38;
  localparam logic [7:0] CH3_VALUE_OFFSET   = 8'h3c;
  localparam logic [7:0] OUT_CTRL_OFFSET    = 8'h44;

  // Reset values.
  localparam logic [15:0] RELOAD_RESET      = 16'hffff;
  localparam logic [15:0] ZERO16            = 16'h0000;

  // Writable bits of the enable register; bits 15:14 stay zero.
  localparam logic [15:0] ENABLE_WMASK      = 16'h3fff;
  localparam logic [15:0] POLARITY_BITS     = 16'h2aaa;

  // Field positions.
  localparam int LEVEL_BIT                  = 16;
  localparam int GATE_BIT                   = 0;
  localparam int IDLE_OFF_BIT               = 1;
  localparam int RUN_OFF_BIT                = 2;
  localparam int IDLE_LEVEL_LSB             = 3;
  localparam int CIDLE_LEVEL_LSB            = 7;
  localparam int LOCK_LSB                   = 8;

  // Direction select encodings.
  localparam logic [1:0] DIR_OUTPUT         = 2'h0;
  localparam logic [1:0] DIR_OWN_PIN        = 2'h1;
  localparam logic [1:0] DIR_PAIR_PIN       = 2'h2;
  localparam logic [1:0] DIR_TRIGGER        = 2'h3;

  // Output modes.
  localparam logic [2:0] MODE_FREEZE        = 3'h0;
  localparam logic [2:0] MODE_SET_MATCH     = 3'h1;
  localparam logic [2:0] MODE_CLR_MATCH     = 3'h2;
  localparam logic [2:0] MODE_TOGGLE        = 3'h3;
  localparam logic [2:0] MODE_FORCE_LOW     = 3'h4;
  localparam logic [2:0] MODE_FORCE_HIGH    = 3'h5;
  localparam logic [2:0] MODE_PWM1          = 3'h6;
  localparam logic [2:0] MODE_PWM2          = 3'h7;

  localparam logic [1:0] LOCK_LEVEL2        = 2'h2;
  localparam logic [1:0] LOCK_LEVEL3        = 2'h3;

  // One channel byte of a mode control register, both layouts.
  typedef struct packed {
    logic       clear_enable;
    logic [2:0] output_mode;
    logic       preload_enable;
    logic       fast_enable;
    logic [3:0] input_filter;
    logic [1:0] capture_divider;
    logic [1:0] channel_direction_select;
  } chan_cfg_t;

  typedef struct packed {
    logic [7:0]  address;
    logic [31:0] data;
    logic        write;
    logic        read;
  } bus_req_t;

endpackage

// ---- advanced_timer_channel_regs.sv ----
`timescale 1ns/1ns
module advanced_timer_channel_regs (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_address,
  input  wire logic [31:0] i_write_data,
  input  wire logic        i_write,
  input  wire logic        i_read,
  output logic      [31:0] o_read_data,
  input  wire logic [3:0]  i_channel_pin,
  input  wire logic        i_trigger_source,
  input  wire logic        i_external_clear,
  output logic      [3:0]  o_channel_out,
  output logic      [3:0]  o_channel_oe,
  output logic      [2:0]  o_complement_out,
  output logic      [2:0]  o_complement_oe,
  output logic             o_update_event,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  adv_timer_pkg::bus_req_t req;
  logic [15:0] mode12_reg;
  logic [15:0] mode34_reg;
  logic [15:0] enable_reg;
  logic [15:0] counter_reg;
  logic [15:0] divider_reg;
  logic [15:0] divcount_reg;
  logic [15:0] reload_reg;
  logic [7:0]  repeat_reg;
  logic [7:0]  repcount_reg;
  logic [15:0] preload_reg [0:2];
  logic [15:0] active_reg  [0:2];
  logic [2:0]  level_reg;
  logic [13:0] outctrl_reg;
  logic        lock_written_reg;
  logic [4:0]  status_reg;
  logic [4:0]  mask_reg;
  logic [3:0]  filt_reg;
  logic [3:0]  filtcnt_reg [0:3];
  logic [3:0]  prev_reg;
  logic [2:0]  edgecnt_reg [0:3];
  logic [3:0]  ref_reg;
  logic [3:0]  sel_level;
  logic [3:0]  edge_hit;
  logic [3:0]  capture;
  logic        tick;
  logic        wrap;
  logic        update;
  logic [1:0]  lock_level;
  adv_timer_pkg::chan_cfg_t cfg [0:3];

  assign req.address = i_address;
  assign req.data    = i_write_data;
  assign req.write   = i_write;
  assign req.read    = i_read;
  assign lock_level  = outctrl_reg[adv_timer_pkg::LOCK_LSB +: 2];

  function automatic adv_timer_pkg::chan_cfg_t decode(input logic [7:0] b);
    adv_timer_pkg::chan_cfg_t c;
    c.clear_enable             = b[7];
    c.output_mode              = b[6:4];
    c.preload_enable           = b[3];
    c.fast_enable              = b[2];
    c.input_filter             = b[7:4];
    c.capture_divider          = b[3:2];
    c.channel_direction_select = b[1:0];
    return c;
  endfunction

  function automatic logic wr_hit(input adv_timer_pkg::bus_req_t r, input logic [7:0] off);
    return r.write && (r.address == off);
  endfunction

  // Keeps a channel's direction bits while it is enabled.
  function automatic logic [15:0] mode_write(input logic [15:0] old, input logic [15:0] nw,
                                             input logic en_lo, input logic en_hi);
    logic [15:0] v;
    v = nw;
    if (en_lo) begin
      v[1:0] = old[1:0];
    end
    if (en_hi) begin
      v[9:8] = old[9:8];
    end
    return v;
  endfunction

  always_comb begin
    cfg[0] = decode(mode12_reg[7:0]);
    cfg[1] = decode(mode12_reg[15:8]);
    cfg[2] = decode(mode34_reg[7:0]);
    cfg[3] = decode(mode34_reg[15:8]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, enable and output-stage registers.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode12_reg <= adv_timer_pkg::ZERO16;
      mode34_reg <= adv_timer_pkg::ZERO16;
    end else if (lock_level != adv_timer_pkg::LOCK_LEVEL3) begin
      if (wr_hit(req, adv_timer_pkg::CH12_MODE_OFFSET)) begin
        mode12_reg <= mode_write(mode12_reg, req.data[15:0], enable_reg[0], enable_reg[4]);
      end
      if (wr_hit(req, adv_timer_pkg::CH34_MODE_OFFSET)) begin
        mode34_reg <= mode_write(mode34_reg, req.data[15:0], enable_reg[8], enable_reg[12]);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      enable_reg <= adv_timer_pkg::ZERO16;
    end else if (wr_hit(req, adv_timer_pkg::ENABLE_OFFSET)) begin
      if (lock_level >= adv_timer_pkg::LOCK_LEVEL2) begin
        enable_reg <= ((req.data[15:0] & ~adv_timer_pkg::POLARITY_BITS) |
                       (enable_reg & adv_timer_pkg::POLARITY_BITS)) & adv_timer_pkg::ENABLE_WMASK;
      end else begin
        enable_reg <= req.data[15:0] & adv_timer_pkg::ENABLE_WMASK;
      end
    end
  end

  // The protection level is write-once until reset.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      outctrl_reg      <= 14'h0000;
      lock_written_reg <= 1'b0;
    end else if (wr_hit(req, adv_timer_pkg::OUT_CTRL_OFFSET)) begin
      outctrl_reg[7:0] <= req.data[7:0];
      outctrl_reg[13:10] <= req.data[13:10];
      if (!lock_written_reg) begin
        outctrl_reg[9:8] <= req.data[9:8];
        lock_written_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      divider_reg <= adv_timer_pkg::ZERO16;
      reload_reg  <= adv_timer_pkg::RELOAD_RESET;
      repeat_reg  <= 8'h00;
    end else begin
      if (wr_hit(req, adv_timer_pkg::DIVIDER_OFFSET)) begin
        divider_reg <= req.data[15:0];
      end
      if (wr_hit(req, adv_timer_pkg::RELOAD_OFFSET)) begin
        reload_reg <= req.data[15:0];
      end
      if (wr_hit(req, adv_timer_pkg::REPEAT_OFFSET)) begin
        repeat_reg <= req.data[7:0];
      end
    end
  end

  assign tick = (divcount_reg == divider_reg);
  assign wrap = tick && (reload_reg != adv_timer_pkg::ZERO16) && (counter_reg == reload_reg);
  assign update = wrap && (repcount_reg == 8'h00);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      divcount_reg <= adv_timer_pkg::ZERO16;
    end else if (tick) begin
      divcount_reg <= adv_timer_pkg::ZERO16;
    end else begin
      divcount_reg <= divcount_reg + 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      counter_reg <= adv_timer_pkg::ZERO16;
    end else if (wr_hit(req, adv_timer_pkg::COUNTER_OFFSET)) begin
      counter_reg <= req.data[15:0];
    end else if (tick && (reload_reg != adv_timer_pkg::ZERO16)) begin
      if (counter_reg == reload_reg) begin
        counter_reg <= adv_timer_pkg::ZERO16;
      end else begin
        counter_reg <= counter_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      repcount_reg <= 8'h00;
    end else if (update) begin
      repcount_reg <= repeat_reg;
    end else if (wrap) begin
      repcount_reg <= repcount_reg - 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_update_event <= 1'b0;
    end else begin
      o_update_event <= update;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input path: filter, source select, edge and capture divider.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      filt_reg <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        filtcnt_reg[c] <= 4'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (i_channel_pin[c] == filt_reg[c]) begin
          filtcnt_reg[c] <= 4'h0;
        end else if (filtcnt_reg[c] >= cfg[c].input_filter) begin
          filt_reg[c]    <= i_channel_pin[c];
          filtcnt_reg[c] <= 4'h0;
        end else begin
          filtcnt_reg[c] <= filtcnt_reg[c] + 4'h1;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      case (cfg[c].channel_direction_select)
        adv_timer_pkg::DIR_OWN_PIN:  sel_level[c] = filt_reg[c];
        adv_timer_pkg::DIR_PAIR_PIN: sel_level[c] = filt_reg[c ^ 1];
        adv_timer_pkg::DIR_TRIGGER:  sel_level[c] = i_trigger_source;
        default:                     sel_level[c] = 1'b0;
      endcase
      // Polarity inverts the signal, so a rising edge of it is a falling pin edge.
      edge_hit[c] = (sel_level[c] ^ enable_reg[4*c+1]) && !prev_reg[c] &&
                    (cfg[c].channel_direction_select != adv_timer_pkg::DIR_OUTPUT) &&
                    enable_reg[4*c];
      capture[c]  = edge_hit[c] && (edgecnt_reg[c] == ((3'h1 << cfg[c].capture_divider) - 3'h1));
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prev_reg <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        edgecnt_reg[c] <= 3'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        prev_reg[c] <= sel_level[c] ^ enable_reg[4*c+1];
        if (!enable_reg[4*c] || capture[c]) begin
          edgecnt_reg[c] <= 3'h0;
        end else if (edge_hit[c]) begin
          edgecnt_reg[c] <= edgecnt_reg[c] + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel value registers; a capture wins over a software write.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      level_reg <= 3'h0;
      for (int c = 0; c < 3; c++) begin
        preload_reg[c] <= adv_timer_pkg::ZERO16;
        active_reg[c]  <= adv_timer_pkg::ZERO16;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (capture[c]) begin
          preload_reg[c] <= counter_reg;
          active_reg[c]  <= counter_reg;
          level_reg[c]   <= sel_level[c];
        end else begin
          if (wr_hit(req, adv_timer_pkg::CH1_VALUE_OFFSET + 8'(4 * c))) begin
            preload_reg[c] <= req.data[15:0];
            if (!cfg[c].preload_enable ||
                cfg[c].channel_direction_select != adv_timer_pkg::DIR_OUTPUT) begin
              active_reg[c] <= req.data[15:0];
            end
          end else if (update) begin
            active_reg[c] <= preload_reg[c];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output reference signals. Channel 4 compares against zero.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_reg <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        logic [15:0] cmp;
        logic        hit;
        cmp = (c < 3) ? active_reg[c] : adv_timer_pkg::ZERO16;
        hit = (counter_reg == cmp);
        if (cfg[c].clear_enable && i_external_clear) begin
          ref_reg[c] <= 1'b0;
        end else begin
          case (cfg[c].output_mode)
            adv_timer_pkg::MODE_FREEZE:     ref_reg[c] <= ref_reg[c];
            adv_timer_pkg::MODE_SET_MATCH:  ref_reg[c] <= hit ? 1'b1 : ref_reg[c];
            adv_timer_pkg::MODE_CLR_MATCH:  ref_reg[c] <= hit ? 1'b0 : ref_reg[c];
            adv_timer_pkg::MODE_TOGGLE:     ref_reg[c] <= hit ? ~ref_reg[c] : ref_reg[c];
            adv_timer_pkg::MODE_FORCE_LOW:  ref_reg[c] <= 1'b0;
            adv_timer_pkg::MODE_FORCE_HIGH: ref_reg[c] <= 1'b1;
            adv_timer_pkg::MODE_PWM1:       ref_reg[c] <= (counter_reg < cmp);
            adv_timer_pkg::MODE_PWM2:       ref_reg[c] <= (counter_reg >= cmp);
            default:                        ref_reg[c] <= 1'b0;
          endcase
        end
      end
    end
  end

  // Pin stage: enable, main gate, off-state selects and idle levels.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_channel_out    <= 4'h0;
      o_channel_oe     <= 4'h0;
      o_complement_out <= 3'h0;
      o_complement_oe  <= 3'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        logic is_out;
        logic pol;
        is_out = (cfg[c].channel_direction_select == adv_timer_pkg::DIR_OUTPUT);
        pol    = enable_reg[4*c+1];
        if (!is_out) begin
          o_channel_oe[c]  <= 1'b0;
          o_channel_out[c] <= 1'b0;
        end else if (!outctrl_reg[adv_timer_pkg::GATE_BIT]) begin
          o_channel_oe[c]  <= outctrl_reg[adv_timer_pkg::IDLE_OFF_BIT];
          o_channel_out[c] <= outctrl_reg[adv_timer_pkg::IDLE_LEVEL_LSB + c];
        end else if (enable_reg[4*c]) begin
          o_channel_oe[c]  <= 1'b1;
          o_channel_out[c] <= ref_reg[c] ^ pol;
        end else begin
          o_channel_oe[c]  <= outctrl_reg[adv_timer_pkg::RUN_OFF_BIT];
          o_channel_out[c] <= pol;
        end
        if (c < 3) begin
          if (!is_out) begin
            o_complement_oe[c]  <= 1'b0;
            o_complement_out[c] <= 1'b0;
          end else if (!outctrl_reg[adv_timer_pkg::GATE_BIT]) begin
            o_complement_oe[c]  <= outctrl_reg[adv_timer_pkg::IDLE_OFF_BIT];
            o_complement_out[c] <= outctrl_reg[adv_timer_pkg::CIDLE_LEVEL_LSB + 3 + c];
          end else if (enable_reg[4*c+2]) begin
            o_complement_oe[c]  <= 1'b1;
            o_complement_out[c] <= ~ref_reg[c] ^ enable_reg[4*c+3];
          end else begin
            o_complement_oe[c]  <= outctrl_reg[adv_timer_pkg::RUN_OFF_BIT];
            o_complement_out[c] <= enable_reg[4*c+3];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: a read clears it, but a new event in that cycle survives.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      status_reg <= 5'h00;
      mask_reg   <= 5'h00;
    end else begin
      status_reg <= ((req.read && req.address == adv_timer_pkg::STATUS_OFFSET) ? 5'h00 : status_reg) |
                    {capture, update};
      if (wr_hit(req, adv_timer_pkg::MASK_OFFSET)) begin
        mask_reg <= req.data[4:0];
      end
    end
  end

  assign o_irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_read_data <= 32'h0000_0000;
    end else if (req.read) begin
      case (req.address)
        adv_timer_pkg::MASK_OFFSET:      o_read_data <= {27'h0, mask_reg};
        adv_timer_pkg::STATUS_OFFSET:    o_read_data <= {27'h0, status_reg};
        adv_timer_pkg::CH12_MODE_OFFSET: o_read_data <= {16'h0, mode12_reg};
        adv_timer_pkg::CH34_MODE_OFFSET: o_read_data <= {16'h0, mode34_reg};
        adv_timer_pkg::ENABLE_OFFSET:    o_read_data <= {16'h0, enable_reg};
        adv_timer_pkg::COUNTER_OFFSET:   o_read_data <= {16'h0, counter_reg};
        adv_timer_pkg::DIVIDER_OFFSET:   o_read_data <= {16'h0, divider_reg};
        adv_timer_pkg::RELOAD_OFFSET:    o_read_data <= {16'h0, reload_reg};
        adv_timer_pkg::REPEAT_OFFSET:    o_read_data <= {24'h0, repeat_reg};
        adv_timer_pkg::CH1_VALUE_OFFSET: o_read_data <= {15'h0, level_reg[0], preload_reg[0]};
        adv_timer_pkg::CH2_VALUE_OFFSET: o_read_data <= {15'h0, level_reg[1], preload_reg[1]};
        adv_timer_pkg::CH3_VALUE_OFFSET: o_read_data <= {15'h0, level_reg[2], preload_reg[2]};
        adv_timer_pkg::OUT_CTRL_OFFSET:  o_read_data <= {18'h0, outctrl_reg};
        default:                         o_read_data <= 32'h0000_0000;
      endcase
    end else begin
      o_read_data <= 32'h0000_0000;
    end
  end

endmodule // advanced_timer_channel_regs

// ---- advanced_timer_channel_regs_props.sv ----
`timescale 1ns/1ns
module advanced_timer_channel_regs_props (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [7:0]  i_address,
  input wire logic [31:0] i_write_data,
  input wire logic        i_write,
  input wire logic        i_read,
  input wire logic [31:0] o_read_data,
  input wire logic        o_update_event,
  input wire logic        o_irq
);
  logic zero_reg;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Remembers whether the last reload write programmed zero.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      zero_reg <= 1'b0;
    end else if (i_write && i_address == adv_timer_pkg::RELOAD_OFFSET) begin
      zero_reg <= i_write_data[15:0] == 16'h0000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ENABLE_TOP: assert property ($past(i_read) && $past(i_address) == adv_timer_pkg::ENABLE_OFFSET
    |-> o_read_data[31:14] == 18'h0) else $error("enable register reserved bits not zero");
  AST_REPEAT_TOP: assert property ($past(i_read) && $past(i_address) == adv_timer_pkg::REPEAT_OFFSET
    |-> o_read_data[31:8] == 24'h0) else $error("repeat register upper byte not zero");
  AST_MODE_TOP: assert property ($past(i_read) && $past(i_address) == adv_timer_pkg::CH34_MODE_OFFSET
    |-> o_read_data[31:16] == 16'h0) else $error("mode register wider than 16 bits");
  AST_DIVIDER_TOP: assert property ($past(i_read) && $past(i_address) == adv_timer_pkg::DIVIDER_OFFSET
    |-> o_read_data[31:16] == 16'h0) else $error("divider register wider than 16 bits");
  AST_VALUE_TOP: assert property ($past(i_read) && $past(i_address) inside {8'h34, 8'h38, 8'h3c}
    |-> o_read_data[31:17] == 15'h0) else $error("value register reserved bits not zero");
  AST_RELOAD_ZERO: assert property (zero_reg && $past(zero_reg, 3) |-> !o_update_event)
    else $error("update event while reload is zero");
  AST_COUNTER_RW: assert property ((i_write && i_address == adv_timer_pkg::COUNTER_OFFSET)
    ##1 (i_read && i_address == adv_timer_pkg::COUNTER_OFFSET)
    |=> o_read_data == {16'h0000, $past(i_write_data[15:0], 2)}) else $error("counter read after write differs");
  AST_UPDATE_PULSE: assert property (o_update_event |=> !o_update_event)
    else $error("update event longer than one cycle");
  cover property (o_update_event);
  cover property (o_irq);
  cover property ($past(i_read) && $past(i_address) == adv_timer_pkg::CH1_VALUE_OFFSET && o_read_data[16]);
endmodule // advanced_timer_channel_regs_props

bind advanced_timer_channel_regs advanced_timer_channel_regs_props u_props (.i_clock(i_clock), .i_rst(i_rst),
  .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
  .o_read_data(o_read_data), .o_update_event(o_update_event), .o_irq(o_irq));

// ---- advanced_timer_channel_regs_test.sv ----
`timescale 1ns/1ns
module advanced_timer_channel_regs_test;
  logic        i_clock, i_rst, i_write, i_read, i_trigger_source, i_external_clear;
  logic [7:0]  i_address;
  logic [31:0] i_write_data, o_read_data, bus_data, v, a, b;
  logic [3:0]  i_channel_pin, o_channel_out, o_channel_oe;
  logic [2:0]  o_complement_out, o_complement_oe;
  logic        o_update_event, o_irq, upd_seen;
  logic [15:0] c;
  int          miscompares, comparisons, n, d;
  advanced_timer_channel_regs u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address),
    .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read), .o_read_data(o_read_data),
    .i_channel_pin(i_channel_pin), .i_trigger_source(i_trigger_source), .i_external_clear(i_external_clear),
    .o_channel_out(o_channel_out), .o_channel_oe(o_channel_oe), .o_complement_out(o_complement_out),
    .o_complement_oe(o_complement_oe), .o_update_event(o_update_event), .o_irq(o_irq));
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One bus cycle; the read data of the previous cycle is caught at its middle.
  task bus(input logic [7:0] ad, input logic [31:0] dt, input logic w, input logic r);
    i_address <= ad;
    i_write_data <= dt;
    i_write <= w;
    i_read <= r;
    @(negedge i_clock);
    bus_data = o_read_data;
    upd_seen = o_update_event;
    @(posedge i_clock);
  endtask
  task idle(input int k);
    repeat (k) bus(8'h00, 32'h0, 1'b0, 1'b0);
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    bus(ad, dt, 1'b1, 1'b0);
  endtask
  task rd(input logic [7:0] ad, output logic [31:0] dt);
    bus(ad, 32'h0, 1'b0, 1'b1);
    idle(1);
    dt = bus_data;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] got;
    rd(ad, got);
    cmp(got, exp);
  endtask
  task do_reset;
    i_rst <= 1'b1;
    idle(6);
    i_rst <= 1'b0;
  endtask
  // Counts cycles up to the next update pulse, seen settled in mid-cycle.
  task wait_upd(output int k);
    k = 0;
    do begin
      idle(1);
      k++;
    end while (upd_seen !== 1'b1 && k < 2000);
  endtask
  function automatic logic [31:0] capture_word(input logic lvl, input logic [15:0] cnt);
    return {15'h0, lvl, cnt};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10000) @(posedge i_clock);
    miscompares++;
    stop_test;
  end
  initial begin
    {i_rst, i_write, i_read, i_trigger_source, i_external_clear} = 5'h10;
    {i_address, i_write_data, i_channel_pin} = '0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(32'hed59));
    do_reset();
    chk(adv_timer_pkg::RELOAD_OFFSET, 32'h0000ffff);
    chk(adv_timer_pkg::ENABLE_OFFSET, 32'h0);
    chk(adv_timer_pkg::REPEAT_OFFSET, 32'h0);
    chk(adv_timer_pkg::CH1_VALUE_OFFSET, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(adv_timer_pkg::CH34_MODE_OFFSET, v);
      chk(adv_timer_pkg::CH34_MODE_OFFSET, {16'h0, v[15:0]});
      wr(adv_timer_pkg::REPEAT_OFFSET, v);
      chk(adv_timer_pkg::REPEAT_OFFSET, {24'h0, v[7:0]});
      wr(adv_timer_pkg::CH1_VALUE_OFFSET + 8'(4 * (i % 3)), v);
      chk(adv_timer_pkg::CH1_VALUE_OFFSET + 8'(4 * (i % 3)), {16'h0, v[15:0]});
      wr(8'h40, v);
      chk(8'h40, 32'h0);
      wr(adv_timer_pkg::ENABLE_OFFSET, v);
      chk(adv_timer_pkg::ENABLE_OFFSET, v & 32'h3fff);
      wr(adv_timer_pkg::ENABLE_OFFSET, 32'h0);
    end
    wr(adv_timer_pkg::MASK_OFFSET, 32'h2);
    wr(adv_timer_pkg::RELOAD_OFFSET, 32'h3);
    wr(adv_timer_pkg::COUNTER_OFFSET, 32'h0);
    wr(adv_timer_pkg::REPEAT_OFFSET, 32'h2);
    wait_upd(n);
    wait_upd(n);
    cmp(n, 32'd12);
    cmp(o_irq, 32'h0);
    c = 16'($urandom);
    wr(adv_timer_pkg::RELOAD_OFFSET, 32'h0);
    wr(adv_timer_pkg::COUNTER_OFFSET, {16'h0, c});
    idle(10);
    chk(adv_timer_pkg::COUNTER_OFFSET, {16'h0, c});
    wr(adv_timer_pkg::OUT_CTRL_OFFSET, 32'h1);
    wr(adv_timer_pkg::CH12_MODE_OFFSET, 32'h50);
    for (int p = 0; p < 2; p++) begin
      wr(adv_timer_pkg::ENABLE_OFFSET, 32'(2 * p + 5));
      idle(4);
      cmp(o_channel_out[0], 32'(1 - p));
      cmp(o_channel_oe[0], 32'h1);
      cmp(o_complement_oe[0], 32'h1);
      cmp(o_complement_out[0], 32'h0);
    end
    wr(adv_timer_pkg::ENABLE_OFFSET, 32'h0);
    idle(4);
    cmp(o_channel_oe[0], 32'h0);
    wr(adv_timer_pkg::CH12_MODE_OFFSET, 32'h1);
    wr(adv_timer_pkg::CH1_VALUE_OFFSET, 32'h0);
    i_channel_pin[0] <= 1'b1;
    idle(8);
    chk(adv_timer_pkg::CH1_VALUE_OFFSET, 32'h0);
    cmp(o_irq, 32'h0);
    i_channel_pin[0] <= 1'b0;
    idle(6);
    for (int p = 0; p < 2; p++) begin
      wr(adv_timer_pkg::ENABLE_OFFSET, 32'h0);
      i_channel_pin[0] <= p[0];
      idle(6);
      wr(adv_timer_pkg::ENABLE_OFFSET, 32'(2 * p + 1));
      c = 16'($urandom);
      wr(adv_timer_pkg::COUNTER_OFFSET, {16'h0, c});
      idle(6);
      rd(adv_timer_pkg::STATUS_OFFSET, v);
      i_channel_pin[0] <= ~p[0];
      idle(8);
      cmp(o_irq, 32'h1);
      chk(adv_timer_pkg::CH1_VALUE_OFFSET, capture_word(~p[0], c));
      chk(adv_timer_pkg::STATUS_OFFSET, 32'h2);
      cmp(o_irq, 32'h0);
    end
    d = $urandom_range(4, 1);
    wr(adv_timer_pkg::RELOAD_OFFSET, 32'hffff);
    wr(adv_timer_pkg::DIVIDER_OFFSET, 32'(d));
    chk(adv_timer_pkg::DIVIDER_OFFSET, 32'(d));
    wr(adv_timer_pkg::COUNTER_OFFSET, 32'h0);
    rd(adv_timer_pkg::COUNTER_OFFSET, a);
    idle(5 * (d + 1) - 2);
    rd(adv_timer_pkg::COUNTER_OFFSET, b);
    cmp(b - a, 32'd5);
    do_reset();
    wr(adv_timer_pkg::OUT_CTRL_OFFSET, 32'h200);
    wr(adv_timer_pkg::ENABLE_OFFSET, 32'h3fff);
    chk(adv_timer_pkg::ENABLE_OFFSET, 32'h3fff & ~{16'h0, adv_timer_pkg::POLARITY_BITS});
    stop_test;
  end
endmodule // advanced_timer_channel_regs_test
